// ---- ccs_pkg.sv ----
package ccs_pkg;
	localparam int         NUM_OUT    = 4;
	localparam int         NUM_PHASE  = 8;
	localparam int         NUM_IN     = 4;
	localparam int         SEL_W      = 4;
	localparam int         CNT_W      = 16;
	localparam int         PPM_W      = 20;
	localparam int         ADDR_W     = 8;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_LOCK_DLY = 8'h04;
	localparam logic [7:0] OFF_LOCK_WIN = 8'h08;
	localparam logic [7:0] OFF_STATUS   = 8'h0C;
	localparam logic [7:0] OFF_OUT_CFG0 = 8'h10;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFF_IRQ_CLR  = 8'h24;
	localparam logic [7:0] OFF_IRQ_EN   = 8'h28;

	// Control register fields
	localparam int         CTRL_SS_BIT  = 0;
	localparam int         CTRL_FB_BIT  = 1;
	localparam int         CTRL_POL_LO  = 2;
	localparam int         CTRL_POL_W   = 2;

	// Reset values
	localparam logic [15:0] LOCK_DLY_RST = 16'h0400;
	localparam logic [19:0] LOCK_WIN_RST = 20'h07D00;
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

	// Source select codes: phases first, then input clocks
	localparam logic [3:0] SEL_FIRST_IN = 4'h8;

	// Interrupt event bits
	localparam int         IRQ_LOCK_UP   = 0;
	localparam int         IRQ_LOCK_DOWN = 1;
	localparam int         IRQ_SWITCHED  = 2;
	localparam int         IRQ_W         = 3;

	typedef enum logic [1:0] {
		CCS_POL_HELD,
		CCS_POL_FREE_RESYNC,
		CCS_POL_NO_RESYNC
	} ccs_policy_e;

	typedef struct packed {
		logic             gate_use;
		logic             invert;
		logic             sec_en;
		logic [SEL_W-1:0] sec_sel;
		logic [SEL_W-1:0] prim_sel;
	} ccs_out_cfg_s;

	localparam int         OUT_CFG_W = $bits(ccs_out_cfg_s);
	localparam logic [10:0] OUT_CFG_RST = 11'h000;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} ccs_apb_req_s;
endpackage : ccs_pkg

// ---- ccs_clock_out.sv ----
// Design decisions made here: the address map and the APB register port.
module ccs_clock_out #(
	parameter int                       NUM_OUT = ccs_pkg::NUM_OUT,
	parameter logic [ccs_pkg::CNT_W-1:0] LOCK_DLY_DEF = ccs_pkg::LOCK_DLY_RST
) (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [ccs_pkg::ADDR_W-1:0]     paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire logic                           ref_clk,
	input  wire logic [ccs_pkg::NUM_IN-1:0]     input_clk,
	input  wire logic [ccs_pkg::NUM_PHASE-1:0]  loop_phase,
	input  wire logic                           loop_phase_ok,
	input  wire logic [ccs_pkg::PPM_W-1:0]      loop_phase_err_ppm,
	input  wire logic                           loop_bypass_low,
	input  wire logic [NUM_OUT-1:0]             global_out_gate_enable,
	input  wire logic [NUM_OUT-1:0]             glitchless_mux_select,
	input  wire logic [NUM_OUT-1:0]             divider_async_reset_low,
	output logic [NUM_OUT-1:0]                  global_clock_out,
	output logic [NUM_OUT-1:0]                  local_clock_out,
	output logic                                loop_lock,
	output logic                                loop_core_on,
	output logic                                loop_fb_internal,
	output logic                                irq
);
	// APB request bundle
	ccs_pkg::ccs_apb_req_s req;
	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	logic [31:0]                 ctrl_reg;
	logic [ccs_pkg::CNT_W-1:0]   lock_dly_reg;
	logic [ccs_pkg::PPM_W-1:0]   lock_win_reg;
	ccs_pkg::ccs_out_cfg_s       out_cfg_reg [NUM_OUT];
	logic [ccs_pkg::IRQ_W-1:0]   irq_stat_reg;
	logic [ccs_pkg::IRQ_W-1:0]   irq_en_reg;
	logic [31:0]                 prdata_reg;
	logic                        pready_reg;
	logic                        pslverr_reg;

	// Bus decode
	wire                          setup_ph  = req.psel & ~req.penable;
	wire                          wr_acc    = req.psel & req.penable & pready_reg & req.pwrite;
	wire                          hit_ctrl  = req.paddr == ccs_pkg::OFF_CTRL;
	wire                          hit_dly   = req.paddr == ccs_pkg::OFF_LOCK_DLY;
	wire                          hit_win   = req.paddr == ccs_pkg::OFF_LOCK_WIN;
	wire                          hit_stat  = req.paddr == ccs_pkg::OFF_STATUS;
	wire                          hit_ist   = req.paddr == ccs_pkg::OFF_IRQ_STAT;
	wire                          hit_iclr  = req.paddr == ccs_pkg::OFF_IRQ_CLR;
	wire                          hit_ien   = req.paddr == ccs_pkg::OFF_IRQ_EN;
	wire                          hit_ocfg  = req.paddr[7:4] == ccs_pkg::OFF_OUT_CFG0[7:4] & req.paddr[1:0] == 2'h0;
	wire [1:0]                    ocfg_idx  = req.paddr[3:2];
	wire                          hit_any   = hit_ctrl | hit_dly | hit_win | hit_stat | hit_ist
		| hit_iclr | hit_ien | hit_ocfg;

	// Configuration decode
	wire                          ss_en     = ctrl_reg[ccs_pkg::CTRL_SS_BIT];
	wire ccs_pkg::ccs_policy_e    policy    = ccs_pkg::ccs_policy_e'(ctrl_reg[ccs_pkg::CTRL_POL_LO +: ccs_pkg::CTRL_POL_W]);

	// Lock tracking
	logic                        ref_prev_reg;
	logic [ccs_pkg::CNT_W-1:0]   lock_cnt_reg;
	logic                        in_lock_reg;
	logic                        lock_reg;
	logic                        div_rst_reg;
	logic                        resync_pend_reg;
	logic                        bypass_reg;
	logic                        core_on_reg;
	logic                        fb_int_reg;
	logic                        any_phase_used;
	logic [NUM_OUT-1:0]          uses_phase;
	logic [NUM_OUT-1:0]          switched;

	wire                          ref_rise  = ref_clk & ~ref_prev_reg;
	wire                          criterion = loop_phase_ok & (loop_phase_err_ppm <= lock_win_reg);
	wire                          loop_off  = ~loop_bypass_low | ~any_phase_used;
	wire                          lock_up   = in_lock_reg & ~lock_reg & ref_rise & (lock_cnt_reg >= lock_dly_reg);
	wire                          lock_down = lock_reg & (~criterion | loop_off);

	// loop used only if some output takes a phase
	assign any_phase_used = |uses_phase;

	// bypassed loop phases all track the reference
	wire [ccs_pkg::NUM_PHASE-1:0] phase_eff = loop_off ? {ccs_pkg::NUM_PHASE{ref_clk}} : loop_phase;
	// source vector, phases below input clocks
	// eight phases, each output picks any
	wire [15:0]                   src_vec   = {{(16 - ccs_pkg::NUM_PHASE - ccs_pkg::NUM_IN){1'b0}},
		input_clk, phase_eff};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_prev_reg <= 1'b0;
			lock_cnt_reg <= '0;
			in_lock_reg  <= 1'b0;
			lock_reg     <= 1'b0;
		end else begin
			ref_prev_reg <= ref_clk;
			if (!criterion || loop_off) begin
				in_lock_reg  <= 1'b0;
				lock_cnt_reg <= '0;
				lock_reg     <= 1'b0;
			end else begin
				in_lock_reg <= 1'b1;
				if (ref_rise && lock_cnt_reg < lock_dly_reg)
					lock_cnt_reg <= lock_cnt_reg + 1'b1;
				if (lock_up)
					lock_reg <= 1'b1;
			end
		end
	end

	// Divider reset per policy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_rst_reg     <= 1'b1;
			resync_pend_reg <= 1'b0;
		end else begin
			case (policy)
				ccs_pkg::CCS_POL_HELD: begin
					// held low until lock, released on reference edge
					if (!lock_reg)
						div_rst_reg <= 1'b1;
					else if (ref_rise)
						div_rst_reg <= 1'b0;
					resync_pend_reg <= 1'b0;
				end
				ccs_pkg::CCS_POL_FREE_RESYNC: begin
					if (lock_up) begin
						div_rst_reg     <= 1'b1;
						resync_pend_reg <= 1'b1;
					end else if (resync_pend_reg && ref_rise) begin
						div_rst_reg     <= 1'b0;
						resync_pend_reg <= 1'b0;
					end
				end
				default: begin
					div_rst_reg     <= 1'b0;
					resync_pend_reg <= 1'b0;
				end
			endcase
		end
	end

	// Loop control outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bypass_reg  <= 1'b1;
			core_on_reg <= 1'b0;
			fb_int_reg  <= 1'b1;
		end else begin
			bypass_reg  <= loop_off;
			core_on_reg <= ~loop_off;
			fb_int_reg  <= ss_en | ~ctrl_reg[ccs_pkg::CTRL_FB_BIT];
		end
	end

	// Per-output glitchless mux, inversion, gating
	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g++) begin : g_out
			logic cur_sec_reg;
			logic en_p_reg;
			logic en_s_reg;
			logic p_prev_reg;
			logic s_prev_reg;
			logic gate_reg;
			logic glob_reg;
			logic loc_reg;

			wire  p_clk  = src_vec[out_cfg_reg[g].prim_sel];
			wire  s_clk  = src_vec[out_cfg_reg[g].sec_sel];
			// mux exists only with a secondary source
			wire  want_s = out_cfg_reg[g].sec_en & glitchless_mux_select[g];
			wire  p_fall = p_prev_reg & ~p_clk;
			wire  s_fall = s_prev_reg & ~s_clk;
			wire  muxed  = (en_p_reg & p_clk) | (en_s_reg & s_clk);
			wire  shaped = (muxed ^ out_cfg_reg[g].invert) & ~div_rst_reg & divider_async_reset_low[g];
			wire  idle   = ~en_p_reg & ~en_s_reg;

			assign uses_phase[g] = out_cfg_reg[g].prim_sel < ccs_pkg::SEL_FIRST_IN
				| (out_cfg_reg[g].sec_en & out_cfg_reg[g].sec_sel < ccs_pkg::SEL_FIRST_IN);
			assign switched[g]   = idle & (cur_sec_reg ? s_fall : p_fall);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cur_sec_reg <= 1'b0;
					en_p_reg    <= 1'b1;
					en_s_reg    <= 1'b0;
					p_prev_reg  <= 1'b0;
					s_prev_reg  <= 1'b0;
				end else begin
					p_prev_reg <= p_clk;
					s_prev_reg <= s_clk;
					// drop old source on its falling edge
					if (want_s != cur_sec_reg) begin
						if ((en_p_reg && p_fall) || (en_s_reg && s_fall) || idle) begin
							en_p_reg    <= 1'b0;
							en_s_reg    <= 1'b0;
							cur_sec_reg <= want_s;
						end
					end else if (switched[g]) begin
						en_p_reg <= ~cur_sec_reg;
						en_s_reg <= cur_sec_reg;
					end
				end
			end

			// Gate changes only while the clock is low so no pulse is clipped
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					gate_reg <= 1'b0;
					glob_reg <= 1'b0;
					loc_reg  <= 1'b0;
				end else begin
					// fabric enable gates the global clock
					if (!shaped)
						gate_reg <= ~out_cfg_reg[g].gate_use | global_out_gate_enable[g];
					glob_reg <= shaped & gate_reg;
					loc_reg  <= shaped;
				end
			end

			assign global_clock_out[g] = glob_reg;
			assign local_clock_out[g]  = loc_reg;
		end
	endgenerate

	wire [ccs_pkg::IRQ_W-1:0] events = {|switched, lock_down, lock_up};

	// Status readback
	wire [31:0] status_word = {26'h0000000, bypass_reg, fb_int_reg, core_on_reg, div_rst_reg, in_lock_reg, lock_reg};
	wire [31:0] rd_mux =
		hit_ctrl ? ctrl_reg :
		hit_dly  ? {16'h0000, lock_dly_reg} :
		hit_win  ? {12'h000, lock_win_reg} :
		hit_stat ? status_word :
		hit_ist  ? {29'h00000000, irq_stat_reg} :
		hit_ien  ? {29'h00000000, irq_en_reg} :
		hit_ocfg ? {21'h000000, out_cfg_reg[ocfg_idx]} :
		32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg     <= ccs_pkg::CTRL_RST;
			lock_dly_reg <= LOCK_DLY_DEF;
			lock_win_reg <= ccs_pkg::LOCK_WIN_RST;
			irq_en_reg   <= '0;
			prdata_reg   <= '0;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
			for (int i = 0; i < NUM_OUT; i++)
				out_cfg_reg[i] <= ccs_pkg::OUT_CFG_RST;
		end else begin
			pready_reg <= 1'b1;
			if (setup_ph) begin
				prdata_reg  <= req.pwrite ? 32'h0000_0000 : rd_mux;
				pslverr_reg <= ~hit_any | (req.pwrite & (hit_stat | hit_ist));
			end
			if (wr_acc && hit_ctrl)
				ctrl_reg <= req.pwdata;
			if (wr_acc && hit_dly)
				lock_dly_reg <= req.pwdata[ccs_pkg::CNT_W-1:0];
			if (wr_acc && hit_win)
				lock_win_reg <= req.pwdata[ccs_pkg::PPM_W-1:0];
			if (wr_acc && hit_ien)
				irq_en_reg <= req.pwdata[ccs_pkg::IRQ_W-1:0];
			if (wr_acc && hit_ocfg)
				out_cfg_reg[ocfg_idx] <= req.pwdata[ccs_pkg::OUT_CFG_W-1:0];
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle
	wire [ccs_pkg::IRQ_W-1:0] clr_mask = (wr_acc && hit_iclr) ? req.pwdata[ccs_pkg::IRQ_W-1:0] : '0;
	logic irq_reg;
	logic lock_out_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= '0;
			irq_reg      <= 1'b0;
			lock_out_reg <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~clr_mask) | events;
			irq_reg      <= |(irq_stat_reg & irq_en_reg);
			lock_out_reg <= lock_reg;
		end
	end

	assign prdata           = prdata_reg;
	assign pready           = pready_reg;
	assign pslverr          = pslverr_reg;
	assign loop_lock        = lock_out_reg;
	assign loop_core_on     = core_on_reg;
	assign loop_fb_internal = fb_int_reg;
	assign irq              = irq_reg;
endmodule : ccs_clock_out

// ---- ccs_fabric_model.sv ----
module ccs_fabric_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	output logic            ref_clk,
	output logic [3:0]      input_clk,
	output logic [7:0]      loop_phase
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cnt_reg <= 5'h00;
		else cnt_reg <= cnt_reg + 5'h01;
	end
	// One counter feeds every source, so all edges stay pclk aligned
	assign ref_clk = cnt_reg[3];
	assign input_clk = cnt_reg[4:1];
	always_comb begin
		for (int k = 0; k < 8; k++) loop_phase[k] = 4'(cnt_reg[3:0] - 4'(2 * k)) < 4'h8;
	end
endmodule : ccs_fabric_model

// ---- ccs_clock_out_chk.sv ----
module ccs_clock_out_chk #(
	parameter int NUM_OUT = ccs_pkg::NUM_OUT
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire logic [31:0]        pwdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               loop_phase_ok,
	input wire logic               loop_bypass_low,
	input wire logic [NUM_OUT-1:0] divider_async_reset_low,
	input wire logic [NUM_OUT-1:0] local_clock_out,
	input wire logic               loop_lock,
	input wire logic               loop_core_on,
	input wire logic               loop_fb_internal,
	input wire logic               irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] ok_cnt_reg;
	wire logic  wr_ok = psel && penable && pwrite && pready;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ok_cnt_reg <= 8'h00;
		else if (!loop_phase_ok) ok_cnt_reg <= 8'h00;
		else if (ok_cnt_reg != 8'hFF) ok_cnt_reg <= ok_cnt_reg + 8'h01;
	end
	// Config writes and divider resets on lock changes may clip a pulse legally; judge the mux only in quiet spells
	logic [7:0] quiet_reg;
	logic       lock_prev_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_reg     <= 8'h00;
			lock_prev_reg <= 1'b0;
		end else begin
			lock_prev_reg <= loop_lock;
			if (wr_ok || loop_lock != lock_prev_reg)
				quiet_reg <= 8'h00;
			else if (quiet_reg != 8'hFF)
				quiet_reg <= quiet_reg + 8'h01;
		end
	end
	property p_ready; $past(presetn) |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_unmap; psel && !penable && paddr == 8'h30 |=> pslverr; endproperty
	a_unmap: assert property (p_unmap) else $error("no slave error");
	property p_bypass; $fell(loop_bypass_low) |-> ##[1:3] !loop_core_on; endproperty
	a_bypass: assert property (p_bypass) else $error("core still on");
	property p_loss; $fell(loop_phase_ok) |-> ##[1:3] !loop_lock; endproperty
	a_loss: assert property (p_loss) else $error("lock kept");
	property p_wait; $rose(loop_lock) |-> ok_cnt_reg > 8'h10; endproperty
	a_wait: assert property (p_wait) else $error("lock too early");
	property p_ss; wr_ok && paddr == 8'h00 && pwdata[0] |-> ##[1:3] loop_fb_internal; endproperty
	a_ss: assert property (p_ss) else $error("feedback not internal");
	property p_mask; wr_ok && paddr == 8'h28 && pwdata[2:0] == 3'h0 |-> ##[1:3] !irq; endproperty
	a_mask: assert property (p_mask) else $error("irq not masked");
	property p_divrst; !divider_async_reset_low[0] [*3] |-> !local_clock_out[0]; endproperty
	a_divrst: assert property (p_divrst) else $error("output not low");
	property p_runt;
		divider_async_reset_low[0] && $past(divider_async_reset_low[0], 3) && quiet_reg > 8'h14
			&& $stable(loop_lock) && $changed(local_clock_out[0])
			|=> $stable(local_clock_out[0]);
	endproperty
	a_runt: assert property (p_runt) else $error("runt pulse");
	c_lock: cover property ($rose(loop_lock));
	c_irq: cover property ($rose(irq));
	c_byp: cover property ($fell(loop_core_on));
endmodule : ccs_clock_out_chk
bind ccs_clock_out ccs_clock_out_chk #(.NUM_OUT(NUM_OUT)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.loop_phase_ok(loop_phase_ok), .loop_bypass_low(loop_bypass_low),
	.divider_async_reset_low(divider_async_reset_low), .local_clock_out(local_clock_out),
	.loop_lock(loop_lock), .loop_core_on(loop_core_on), .loop_fb_internal(loop_fb_internal), .irq(irq)
);

// ---- clock_output_select_gate_lock_tb_top.sv ----
module clock_output_select_gate_lock_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  pclk;
	logic                  presetn;
	ccs_pkg::ccs_apb_req_s req;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  ref_clk;
	logic [3:0]            input_clk;
	logic [7:0]            loop_phase;
	logic                  ok;
	logic [19:0]           err;
	logic                  byp_low;
	logic [3:0]            gate_en;
	logic [3:0]            mux_sel;
	logic [3:0]            div_rst_low;
	logic [3:0]            gco;
	logic [3:0]            lco;
	logic                  lock;
	logic                  core_on;
	logic                  fb_int;
	logic                  irq;
	logic [31:0]           rdat;
	logic                  rerr;
	int                    n_mismatch;
	int                    n_compared;
	int                    cyc;
	int                    c;
	wire logic [11:0]      src = {input_clk, loop_phase};
	ccs_clock_out DUT (
		.pclk(pclk), .presetn(presetn), .psel(req.psel), .penable(req.penable), .pwrite(req.pwrite),
		.paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ref_clk(ref_clk), .input_clk(input_clk), .loop_phase(loop_phase), .loop_phase_ok(ok),
		.loop_phase_err_ppm(err), .loop_bypass_low(byp_low), .global_out_gate_enable(gate_en),
		.glitchless_mux_select(mux_sel), .divider_async_reset_low(div_rst_low),
		.global_clock_out(gco), .local_clock_out(lco), .loop_lock(lock), .loop_core_on(core_on),
		.loop_fb_internal(fb_int), .irq(irq)
	);
	ccs_fabric_model u_fab (.pclk(pclk), .presetn(presetn), .ref_clk(ref_clk), .input_clk(input_clk),
		.loop_phase(loop_phase));
	always #2.5 pclk = ~pclk;
	// Default lock delay alone needs about 16400 cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch = n_mismatch + 1;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [32:0] g, input logic [32:0] e, input string m);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		req <= '{1'b0, 1'b0, w, a, d};
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk({rerr, rdat & m}, {1'b0, e}, "read");
	endtask : rd
	task automatic flag(input logic g, input logic e, input string m);
		chk({32'h0, g}, {32'h0, e}, m);
	endtask : flag
	task automatic wlock(input int n);
		for (int i = 0; i < n && lock !== 1'b1; i++) @(posedge pclk);
	endtask : wlock
	task automatic cnt(input int n, input logic g, output int k);
		logic p;
		p = g ? gco[0] : lco[0];
		k = 0;
		repeat (n) begin
			@(posedge pclk);
			if ((g ? gco[0] : lco[0]) !== p) k++;
			p = g ? gco[0] : lco[0];
		end
	endtask : cnt
	// Output follows its source a few cycles after the source rises
	task automatic lvl(input int s, input logic e);
		wait (src[s] === 1'b0);
		wait (src[s] === 1'b1);
		wt(4);
		flag(lco[0], e, "level");
	endtask : lvl
	task automatic t_regs();
		rd(ccs_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
		rd(ccs_pkg::OFF_LOCK_DLY, 32'hFFFF_FFFF, 32'h0000_0400);
		rd(ccs_pkg::OFF_LOCK_WIN, 32'hFFFF_FFFF, 32'h0000_7D00);
		rd(ccs_pkg::OFF_OUT_CFG0, 32'hFFFF_FFFF, 32'h0000_0000);
		xfer(1'b0, 8'h30, 32'h0);
		chk({rerr, rdat}, 33'h1_0000_0000, "unmapped");
		xfer(1'b1, ccs_pkg::OFF_STATUS, 32'hFFFF_FFFF);
		flag(rerr, 1'b1, "ro write");
		for (int i = 0; i < 4; i++) xfer(1'b1, ccs_pkg::OFF_OUT_CFG0 + 8'(4 * i), 32'(8 + i));
		rd(ccs_pkg::OFF_STATUS, 32'h20, 32'h20);
		$display("t_regs end");
	endtask : t_regs
	task automatic t_lock();
		xfer(1'b1, ccs_pkg::OFF_OUT_CFG0 + 8'h04, 32'h3);
		ok <= 1'b1;
		wt(20);
		rd(ccs_pkg::OFF_STATUS, 32'h3, 32'h2);
		cnt(40, 1'b0, c);
		chk(33'(c), 33'h0, "held");
		wt(16000);
		flag(lock, 1'b0, "early");
		wlock(1600);
		flag(lock, 1'b1, "lock");
		wt(20);
		cnt(40, 1'b0, c);
		flag(c > 4, 1'b1, "released");
		rd(ccs_pkg::OFF_IRQ_STAT, 32'h1, 32'h1);
		$display("t_lock end");
	endtask : t_lock
	task automatic t_win();
		xfer(1'b1, ccs_pkg::OFF_LOCK_DLY, 32'h4);
		xfer(1'b1, ccs_pkg::OFF_IRQ_CLR, 32'h7);
		xfer(1'b1, ccs_pkg::OFF_IRQ_EN, 32'h2);
		err <= 20'h07D01;
		wt(6);
		chk({31'h0, lock, irq}, 33'h1, "outside window");
		xfer(1'b1, ccs_pkg::OFF_IRQ_EN, 32'h0);
		wt(3);
		flag(irq, 1'b0, "masked");
		xfer(1'b1, ccs_pkg::OFF_IRQ_EN, 32'h2);
		wt(3);
		flag(irq, 1'b1, "unmasked");
		xfer(1'b1, ccs_pkg::OFF_IRQ_CLR, 32'h2);
		wt(3);
		flag(irq, 1'b0, "cleared");
		err <= 20'h07D00;
		wlock(200);
		flag(lock, 1'b1, "window edge");
		$display("t_win end");
	endtask : t_win
	task automatic t_out();
		xfer(1'b1, ccs_pkg::OFF_CTRL, 32'h8);
		for (int k = 0; k < 10; k++) begin
			xfer(1'b1, ccs_pkg::OFF_OUT_CFG0, 32'(k < 8 ? k : k + 2));
			lvl(k < 8 ? k : k + 2, 1'b1);
		end
		xfer(1'b1, ccs_pkg::OFF_OUT_CFG0, 32'h20B);
		lvl(11, 1'b0);
		xfer(1'b1, ccs_pkg::OFF_OUT_CFG0, 32'h3B8);
		wt(24);
		mux_sel <= 4'h1;
		wt(80);
		lvl(11, 1'b0);
		cnt(32, 1'b0, c);
		chk(33'(c), 33'h2, "secondary");
		rd(ccs_pkg::OFF_IRQ_STAT, 32'h4, 32'h4);
		mux_sel <= 4'h0;
		xfer(1'b1, ccs_pkg::OFF_OUT_CFG0, 32'h40B);
		wt(24);
		cnt(64, 1'b1, c);
		chk(33'(c), 33'h0, "gated");
		gate_en <= 4'h1;
		wt(8);
		cnt(64, 1'b1, c);
		flag(c > 0, 1'b1, "ungated");
		div_rst_low <= 4'hE;
		wt(4);
		cnt(32, 1'b0, c);
		chk(33'(c), 33'h0, "divider reset");
		div_rst_low <= 4'hF;
		$display("t_out end");
	endtask : t_out
	task automatic t_ctrl();
		xfer(1'b1, ccs_pkg::OFF_CTRL, 32'hA);
		wt(4);
		flag(fb_int, 1'b0, "fb external");
		xfer(1'b1, ccs_pkg::OFF_CTRL, 32'hB);
		wt(4);
		flag(fb_int, 1'b1, "ss forces");
		byp_low <= 1'b0;
		wt(4);
		flag(core_on, 1'b0, "bypass");
		rd(ccs_pkg::OFF_STATUS, 32'h8, 32'h0);
		byp_low <= 1'b1;
		xfer(1'b1, ccs_pkg::OFF_CTRL, 32'h4);
		ok <= 1'b0;
		wt(8);
		cnt(64, 1'b0, c);
		flag(c > 0, 1'b1, "free run");
		xfer(1'b1, ccs_pkg::OFF_OUT_CFG0, 32'h8);
		ok <= 1'b1;
		wlock(300);
		cnt(8, 1'b0, c);
		chk(33'(c), 33'h0, "resync hold");
		wt(16);
		cnt(8, 1'b0, c);
		flag(c > 2, 1'b1, "resync release");
		xfer(1'b1, ccs_pkg::OFF_CTRL, 32'h8);
		ok <= 1'b0;
		wt(4);
		ok <= 1'b1;
		wlock(300);
		cnt(8, 1'b0, c);
		flag(c > 2, 1'b1, "no resync");
		$display("t_ctrl end");
	endtask : t_ctrl
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		req = '0;
		ok = 1'b0;
		err = 20'h00000;
		byp_low = 1'b1;
		gate_en = 4'h0;
		mux_sel = 4'h0;
		div_rst_low = 4'hF;
		n_mismatch = 0;
		n_compared = 0;
		cyc = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_lock();
		t_win();
		t_out();
		t_ctrl();
		print_verdict();
	end
endmodule : clock_output_select_gate_lock_tb_top
